// >>> rtl/alc_pkg.sv
// Purpose: constants for the alternate-space access legality checker
// Assumes: 8-bit space identifiers, 64-bit addresses and data
// Notes: twin, commit and scratchpad space identifier values and the scratchpad index field live here
//
// Overview of operation
// RULE1: twin spaces 26/2E with twin load use real address, no context.
// RULE2: twin spaces E2/EA use primary context, E3/EB secondary, virtual address.
// RULE3: 26/E2/E3 big-endian when invert bit 0; 2E/EA/EB reversed.
// RULE4: twin space with twin load faults misaligned unless 16-byte aligned.
// RULE5: twin space with other instruction raises invalid space, never misaligned.
// RULE6: block spaces with double float load/store need 64-byte alignment.
// RULE7: commit-only block spaces with double float load follow that load's own handling.
// RULE8: block space with other instruction raises invalid space, no misaligned.
// RULE9: masked store spaces C0-C5, C8-CD with float store need 8-byte alignment.
// RULE10: float store immediate form with masked store space is illegal instruction.
// RULE11: masked store space with other instruction raises invalid space only; code defers a double float load to the load instead.
// RULE12: short float spaces D0-D3, D8-DB; 16-bit ones need halfword alignment.
// RULE13: short float space with other instruction raises invalid space, no misaligned.
// RULE14: eight 64-bit scratchpad registers read and written via scratchpad space.
// RULE15: scratchpad contents change only by software writes.
// RULE16: scratchpads 4-7 fully, slowly, or not accessible; inaccessible raises invalid space.
// RULE17: scratchpad space only with 64-bit alt load/store, else invalid space.
// RULE18: any fault aborts the access and reports exactly one cause.
package alc_pkg;
  localparam int ASI_W = 8;
  localparam logic [7:0] SP_TWIN_REAL = 8'h26;
  localparam logic [7:0] SP_TWIN_REAL_LE = 8'h2E;
  localparam logic [7:0] SP_TWIN_PRI = 8'hE2;
  localparam logic [7:0] SP_TWIN_SEC = 8'hE3;
  localparam logic [7:0] SP_TWIN_PRI_LE = 8'hEA;
  localparam logic [7:0] SP_TWIN_SEC_LE = 8'hEB;
  localparam logic [7:0] SP_SCRATCH = 8'h20;
  localparam logic [7:0] SP_COMMIT_P = 8'hE0;
  localparam logic [7:0] SP_COMMIT_S = 8'hE1;
  localparam logic [3:0] ALIGN16_MASK = 4'hF;
  localparam logic [5:0] ALIGN64_MASK = 6'h3F;
  localparam logic [2:0] ALIGN8_MASK = 3'h7;
  localparam logic ALIGN2_MASK = 1'b1;
  // scratchpad index taken from address bits [5:3]
  localparam int SCR_IDX_LSB = 3;
  localparam int SCR_COUNT = 8;
  localparam logic [63:0] SCR_RESET = 64'h0000_0000_0000_0000;
  // per-register access modes for scratchpads 4..7
  localparam logic [1:0] SCR_FULL = 2'h0;
  localparam logic [1:0] SCR_SLOW = 2'h1;
  localparam logic [1:0] SCR_NONE = 2'h2;
  localparam int SLOW_CYCLES = 4;

  typedef enum logic [2:0] {
    OP_TWIN_LOAD,
    OP_DF_LOAD,
    OP_DF_STORE,
    OP_X_LOAD,
    OP_X_STORE,
    OP_PREFETCH,
    OP_OTHER_ALT
  } alc_op_t;

  typedef enum logic [2:0] {
    CAUSE_NONE,
    CAUSE_INVALID_ASI,
    CAUSE_MISALIGN,
    CAUSE_ILLEGAL,
    CAUSE_DF_MISALIGN
  } alc_cause_t;

  typedef enum logic [1:0] {
    CTX_NONE,
    CTX_PRIMARY,
    CTX_SECONDARY
  } alc_ctx_t;
endpackage : alc_pkg

// >>> rtl/alc_scratch_mem.sv
// Purpose: eight-word scratchpad store with registered read data
// Assumes: one access per cycle
// Notes: contents change only on write strobe or reset
module alc_scratch_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 64
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [$clog2(DEPTH)-1:0] idx,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // RULE15: software writes only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < DEPTH; k++) begin
        mem[k] <= alc_pkg::SCR_RESET;
      end
    end else if (wr_en) begin
      mem[idx] <= wr_data;
    end
  end

  // registered read port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= alc_pkg::SCR_RESET;
    end else if (rd_en) begin
      rd_data <= mem[idx];
    end
  end
endmodule : alc_scratch_mem

// >>> rtl/alc_checker.sv
// Purpose: legality check of alternate-space accesses and scratchpad access
// Assumes: one request per valid pulse from the load/store pipeline
// Notes: verdict appears one cycle after the request, scratch data later
module alc_checker #(
  parameter logic [7:0] SCR_MODE_4_7 = {alc_pkg::SCR_FULL, alc_pkg::SCR_SLOW, alc_pkg::SCR_FULL, alc_pkg::SCR_NONE}
) (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic REQ_VALID,
  input wire alc_pkg::alc_op_t REQ_OP,
  input wire logic [7:0] REQ_ASI,
  input wire logic [63:0] REQ_ADDR,
  input wire logic REQ_IMM,
  input wire logic REQ_SHORT16,
  input wire logic INVERT_ENDIAN_BIT,
  input wire logic [63:0] REQ_WDATA,
  output logic RSP_VALID,
  output alc_pkg::alc_cause_t RSP_CAUSE,
  output logic RSP_PROCEED,
  output logic RSP_REAL_ADDR,
  output alc_pkg::alc_ctx_t RSP_CTX,
  output logic RSP_LITTLE,
  output logic RSP_ATOMIC128,
  output logic RSP_BLOCK,
  output logic RSP_PARTIAL,
  output logic RSP_SHORT,
  output logic RSP_DEFER_TO_LOAD,
  output logic RD_VALID,
  output logic [63:0] RD_DATA,
  output logic BUSY
);
  logic rst_meta;
  logic rst_n;
  logic is_twin, is_block, is_commit, is_part, is_short, is_scr;
  logic twin_le;
  logic [2:0] scr_idx;
  logic [1:0] scr_mode;
  alc_pkg::alc_cause_t next_cause;
  logic next_real, next_little, next_a128, next_block, next_part, next_short, next_defer;
  alc_pkg::alc_ctx_t next_ctx;
  logic scr_wr, scr_rd;
  logic [63:0] mem_rd;
  logic rd_pend;
  logic [2:0] slow_cnt;

  // reset release through two flops
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  function automatic logic aligned(input logic [63:0] a, input logic [5:0] m);
    aligned = ((a[5:0] & m) == 6'h00);
  endfunction : aligned

  // space classification
  always_comb begin
    is_twin = (REQ_ASI == alc_pkg::SP_TWIN_REAL) || (REQ_ASI == alc_pkg::SP_TWIN_REAL_LE) ||
              (REQ_ASI == alc_pkg::SP_TWIN_PRI) || (REQ_ASI == alc_pkg::SP_TWIN_SEC) ||
              (REQ_ASI == alc_pkg::SP_TWIN_PRI_LE) || (REQ_ASI == alc_pkg::SP_TWIN_SEC_LE);
    is_commit = (REQ_ASI == alc_pkg::SP_COMMIT_P) || (REQ_ASI == alc_pkg::SP_COMMIT_S);
    is_block = (REQ_ASI == 8'h16) || (REQ_ASI == 8'h17) || (REQ_ASI == 8'h1E) ||
               (REQ_ASI == 8'h1F) || (REQ_ASI == 8'hF0) || (REQ_ASI == 8'hF1) ||
               (REQ_ASI == 8'hF8) || (REQ_ASI == 8'hF9) || is_commit;
    is_part = (REQ_ASI[7:4] == 4'hC) && (REQ_ASI[2:0] <= 3'h5);
    is_short = (REQ_ASI[7:4] == 4'hD) && (REQ_ASI[2] == 1'b0);
    is_scr = (REQ_ASI == alc_pkg::SP_SCRATCH);
    twin_le = (REQ_ASI == alc_pkg::SP_TWIN_REAL_LE) || (REQ_ASI == alc_pkg::SP_TWIN_PRI_LE) ||
              (REQ_ASI == alc_pkg::SP_TWIN_SEC_LE);
    scr_idx = REQ_ADDR[alc_pkg::SCR_IDX_LSB +: 3];
    scr_mode = scr_idx[2] ? SCR_MODE_4_7[scr_idx[1:0]*2 +: 2] : alc_pkg::SCR_FULL;
  end

  // verdict decode, one cause at most
  always_comb begin
    next_cause = alc_pkg::CAUSE_NONE;
    next_real = 1'b0;
    next_ctx = alc_pkg::CTX_NONE;
    next_little = 1'b0;
    next_a128 = 1'b0;
    next_block = 1'b0;
    next_part = 1'b0;
    next_short = 1'b0;
    next_defer = 1'b0;
    if (is_twin) begin
      if (REQ_OP == alc_pkg::OP_TWIN_LOAD) begin
        // RULE4: 16-byte alignment
        if (!aligned(REQ_ADDR, {2'h0, alc_pkg::ALIGN16_MASK})) begin
          next_cause = alc_pkg::CAUSE_MISALIGN;
        end
        next_a128 = 1'b1;
        // RULE1: real address, no context
        if ((REQ_ASI == alc_pkg::SP_TWIN_REAL) || (REQ_ASI == alc_pkg::SP_TWIN_REAL_LE)) begin
          next_real = 1'b1;
        // RULE2: primary or secondary context
        end else if ((REQ_ASI == alc_pkg::SP_TWIN_PRI) || (REQ_ASI == alc_pkg::SP_TWIN_PRI_LE)) begin
          next_ctx = alc_pkg::CTX_PRIMARY;
        end else begin
          next_ctx = alc_pkg::CTX_SECONDARY;
        end
        // RULE3: endian from invert bit
        next_little = INVERT_ENDIAN_BIT ^ twin_le;
      end else begin
        // RULE5: invalid space only
        next_cause = alc_pkg::CAUSE_INVALID_ASI;
      end
    end else if (is_block) begin
      if ((REQ_OP == alc_pkg::OP_DF_LOAD) && is_commit) begin
        // RULE7: handled by the load itself
        next_defer = 1'b1;
      end else if ((REQ_OP == alc_pkg::OP_DF_LOAD) || (REQ_OP == alc_pkg::OP_DF_STORE)) begin
        // RULE6: 64-byte alignment
        if (!aligned(REQ_ADDR, alc_pkg::ALIGN64_MASK)) begin
          next_cause = alc_pkg::CAUSE_MISALIGN;
        end
        next_block = 1'b1;
      end else begin
        // RULE8: invalid space only
        next_cause = alc_pkg::CAUSE_INVALID_ASI;
      end
    end else if (is_part) begin
      if (REQ_OP == alc_pkg::OP_DF_STORE) begin
        // RULE10: immediate form illegal
        if (REQ_IMM) begin
          next_cause = alc_pkg::CAUSE_ILLEGAL;
        // RULE9: 8-byte alignment
        end else if (!aligned(REQ_ADDR, {3'h0, alc_pkg::ALIGN8_MASK})) begin
          next_cause = alc_pkg::CAUSE_MISALIGN;
        end
        next_part = 1'b1;
      end else if (REQ_OP == alc_pkg::OP_DF_LOAD) begin
        next_defer = 1'b1;
      end else begin
        // RULE11: invalid space only
        next_cause = alc_pkg::CAUSE_INVALID_ASI;
      end
    end else if (is_short) begin
      if ((REQ_OP == alc_pkg::OP_DF_LOAD) || (REQ_OP == alc_pkg::OP_DF_STORE)) begin
        // RULE12: halfword alignment for 16-bit
        if (REQ_SHORT16 && !aligned(REQ_ADDR, {5'h00, alc_pkg::ALIGN2_MASK})) begin
          next_cause = alc_pkg::CAUSE_MISALIGN;
        end
        next_short = 1'b1;
      end else begin
        // RULE13: invalid space only
        next_cause = alc_pkg::CAUSE_INVALID_ASI;
      end
    end else if (is_scr) begin
      // RULE17: 64-bit alt load/store only
      if ((REQ_OP != alc_pkg::OP_X_LOAD) && (REQ_OP != alc_pkg::OP_X_STORE)) begin
        next_cause = alc_pkg::CAUSE_INVALID_ASI;
      // RULE16: inaccessible upper scratchpads
      end else if (scr_mode == alc_pkg::SCR_NONE) begin
        next_cause = alc_pkg::CAUSE_INVALID_ASI;
      end
    end
  end

  // RULE14: scratch access only when legal
  always_comb begin
    scr_wr = REQ_VALID && !BUSY && is_scr && (REQ_OP == alc_pkg::OP_X_STORE) &&
             (next_cause == alc_pkg::CAUSE_NONE);
    scr_rd = REQ_VALID && !BUSY && is_scr && (REQ_OP == alc_pkg::OP_X_LOAD) &&
             (next_cause == alc_pkg::CAUSE_NONE);
  end

  alc_scratch_mem #(
    .DEPTH(alc_pkg::SCR_COUNT),
    .WIDTH(64)
  ) u_mem (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .wr_en(scr_wr),
    .rd_en(scr_rd),
    .idx(scr_idx),
    .wr_data(REQ_WDATA),
    .rd_data(mem_rd)
  );

  // RULE18: abort on fault, single cause
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      RSP_VALID <= 1'b0;
      RSP_CAUSE <= alc_pkg::CAUSE_NONE;
      RSP_PROCEED <= 1'b0;
      RSP_REAL_ADDR <= 1'b0;
      RSP_CTX <= alc_pkg::CTX_NONE;
      RSP_LITTLE <= 1'b0;
      RSP_ATOMIC128 <= 1'b0;
      RSP_BLOCK <= 1'b0;
      RSP_PARTIAL <= 1'b0;
      RSP_SHORT <= 1'b0;
      RSP_DEFER_TO_LOAD <= 1'b0;
    end else begin
      RSP_VALID <= REQ_VALID && !BUSY;
      RSP_CAUSE <= next_cause;
      RSP_PROCEED <= REQ_VALID && !BUSY && (next_cause == alc_pkg::CAUSE_NONE);
      RSP_REAL_ADDR <= next_real;
      RSP_CTX <= next_ctx;
      RSP_LITTLE <= next_little;
      RSP_ATOMIC128 <= next_a128 && (next_cause == alc_pkg::CAUSE_NONE);
      RSP_BLOCK <= next_block && (next_cause == alc_pkg::CAUSE_NONE);
      RSP_PARTIAL <= next_part && (next_cause == alc_pkg::CAUSE_NONE);
      RSP_SHORT <= next_short && (next_cause == alc_pkg::CAUSE_NONE);
      RSP_DEFER_TO_LOAD <= next_defer;
    end
  end

  // RULE16: slow upper scratch reads
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      BUSY <= 1'b0;
      slow_cnt <= 3'h0;
      rd_pend <= 1'b0;
    end else if (scr_rd) begin
      rd_pend <= 1'b1;
      BUSY <= (scr_mode == alc_pkg::SCR_SLOW);
      slow_cnt <= (scr_mode == alc_pkg::SCR_SLOW) ? 3'(alc_pkg::SLOW_CYCLES) : 3'h0;
    end else if (slow_cnt != 3'h0) begin
      slow_cnt <= slow_cnt - 3'h1;
      BUSY <= (slow_cnt != 3'h1);
    end else begin
      rd_pend <= 1'b0;
      BUSY <= 1'b0;
    end
  end

  // read data return
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      RD_VALID <= 1'b0;
      RD_DATA <= alc_pkg::SCR_RESET;
    end else begin
      RD_VALID <= rd_pend && (slow_cnt == 3'h0); // a read taken now must not swallow the pending word
      RD_DATA <= mem_rd;
    end
  end
endmodule : alc_checker

// >>> tb/alc_checker_properties.sv
// Purpose: properties of the space-id legality checker
// Assumes: one clock domain, a request while busy is not taken
// Notes: verdict looked at one cycle after the taking edge
module alc_checker_properties #(
  parameter logic [7:0] SCR_MODE_4_7 = 8'h00
) (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic REQ_VALID,
  input wire alc_pkg::alc_op_t REQ_OP,
  input wire logic [7:0] REQ_ASI,
  input wire logic [63:0] REQ_ADDR,
  input wire logic REQ_IMM,
  input wire logic REQ_SHORT16,
  input wire logic INVERT_ENDIAN_BIT,
  input wire logic BUSY,
  input wire logic RSP_VALID,
  input wire alc_pkg::alc_cause_t RSP_CAUSE,
  input wire logic RSP_PROCEED,
  input wire logic RSP_REAL_ADDR,
  input wire alc_pkg::alc_ctx_t RSP_CTX,
  input wire logic RSP_LITTLE,
  input wire logic RSP_ATOMIC128,
  input wire logic RSP_BLOCK,
  input wire logic RSP_PARTIAL,
  input wire logic RSP_SHORT,
  input wire logic RSP_DEFER_TO_LOAD,
  input wire logic RD_VALID
);
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (!RSTN);
  // request class and verdict decode
  wire take = REQ_VALID && !BUSY;
  wire twin = REQ_ASI inside {8'h26, 8'h2E, 8'hE2, 8'hE3, 8'hEA, 8'hEB};
  wire blk = REQ_ASI inside {8'h16, 8'h17, 8'hF0, 8'hF1, 8'hF8, 8'hF9};
  wire part = REQ_ASI inside {[8'hC0:8'hC5], [8'hC8:8'hCD]};
  wire shrt = REQ_ASI inside {[8'hD0:8'hD3], [8'hD8:8'hDB]};
  wire commit = REQ_ASI inside {8'hE0, 8'hE1};
  wire df = REQ_OP inside {alc_pkg::OP_DF_LOAD, alc_pkg::OP_DF_STORE};
  wire st = REQ_OP == alc_pkg::OP_DF_STORE;
  wire xacc = REQ_OP inside {alc_pkg::OP_X_LOAD, alc_pkg::OP_X_STORE};
  wire tl = REQ_OP == alc_pkg::OP_TWIN_LOAD;
  wire inv = RSP_CAUSE == alc_pkg::CAUSE_INVALID_ASI;
  wire mis = RSP_CAUSE == alc_pkg::CAUSE_MISALIGN;
  // aligned twin load, fast scratch read
  sequence s_twin_ok;
    take && twin && tl && REQ_ADDR[3:0] == 4'h0;
  endsequence
  sequence s_fast_rd;
    take && REQ_OP == alc_pkg::OP_X_LOAD && REQ_ASI == alc_pkg::SP_SCRATCH && !REQ_ADDR[5];
  endsequence
  chk_one_verdict: assert property (take |=> RSP_VALID && RSP_PROCEED == (RSP_CAUSE == alc_pkg::CAUSE_NONE))
    else $error("verdict missing or not unique");
  chk_twin_real: assert property (s_twin_ok ##0 !REQ_ASI[7] |=> RSP_REAL_ADDR)
    else $error("twin real space not real");
  chk_twin_endian: assert property (s_twin_ok |=> RSP_LITTLE == ($past(INVERT_ENDIAN_BIT) ^ $past(REQ_ASI[3])))
    else $error("twin endianness wrong");
  chk_twin_misalign: assert property (take && twin && tl && REQ_ADDR[3:0] != 4'h0 |=> mis)
    else $error("twin misalign missing");
  chk_twin_invalid: assert property (take && twin && !tl |=> inv)
    else $error("twin space misuse not invalid");
  chk_block_misalign: assert property (take && blk && df && REQ_ADDR[5:0] != 6'h00 |=> mis)
    else $error("block misalign missing");
  chk_block_invalid: assert property (take && blk && !df |=> inv)
    else $error("block space misuse not invalid");
  chk_part_illegal: assert property (take && part && REQ_OP == alc_pkg::OP_DF_STORE && REQ_IMM |=>
    RSP_CAUSE == alc_pkg::CAUSE_ILLEGAL) else $error("masked store immediate not illegal");
  chk_scr_fast: assert property (s_fast_rd |-> ##2 RD_VALID)
    else $error("fast scratch read late");
  chk_scr_denied: assert property (take && REQ_ASI == alc_pkg::SP_SCRATCH && REQ_ADDR[5:3] == 3'h4 &&
    SCR_MODE_4_7[1:0] == alc_pkg::SCR_NONE |=> inv) else $error("denied scratch not invalid");
  chk_twin_ctx: assert property (s_twin_ok ##0 REQ_ASI[7] |=>
    RSP_CTX == ($past(REQ_ASI[0]) ? alc_pkg::CTX_SECONDARY : alc_pkg::CTX_PRIMARY))
    else $error("twin context wrong");
  chk_twin_atomic: assert property (s_twin_ok |=> RSP_ATOMIC128 && RSP_PROCEED)
    else $error("aligned twin load not atomic");
  chk_block_ok: assert property (take && blk && df && REQ_ADDR[5:0] == 6'h00 |=> RSP_BLOCK && RSP_PROCEED)
    else $error("aligned block transfer refused");
  chk_commit_defer: assert property (take && commit && REQ_OP == alc_pkg::OP_DF_LOAD |=>
    RSP_DEFER_TO_LOAD && RSP_CAUSE == alc_pkg::CAUSE_NONE) else $error("commit space load not deferred");
  chk_part_misalign: assert property (take && part && st && !REQ_IMM && REQ_ADDR[2:0] != 3'h0 |=> mis)
    else $error("masked store misalign missing");
  chk_part_invalid: assert property (take && part && !df |=> inv)
    else $error("masked store space misuse not invalid");
  chk_short_half: assert property (take && shrt && df && REQ_SHORT16 && REQ_ADDR[0] |=> mis)
    else $error("short halfword misalign missing");
  chk_short_invalid: assert property (take && shrt && !df |=> inv)
    else $error("short space misuse not invalid");
  chk_scr_opcode: assert property (take && REQ_ASI == alc_pkg::SP_SCRATCH && !xacc |=> inv)
    else $error("scratch space misuse not invalid");
  chk_fault_quiet: assert property (RSP_VALID && RSP_CAUSE != alc_pkg::CAUSE_NONE |->
    !(RSP_PROCEED || RSP_ATOMIC128 || RSP_BLOCK || RSP_PARTIAL || RSP_SHORT))
    else $error("faulting access not aborted");
endmodule : alc_checker_properties

bind alc_checker alc_checker_properties #(.SCR_MODE_4_7(SCR_MODE_4_7)) u_props (
  .CORE_CLK, .RSTN, .REQ_VALID, .REQ_OP, .REQ_ASI, .REQ_ADDR, .REQ_IMM, .REQ_SHORT16, .INVERT_ENDIAN_BIT, .BUSY,
  .RSP_VALID, .RSP_CAUSE, .RSP_PROCEED, .RSP_REAL_ADDR, .RSP_CTX, .RSP_LITTLE, .RSP_ATOMIC128, .RSP_BLOCK,
  .RSP_PARTIAL, .RSP_SHORT, .RSP_DEFER_TO_LOAD, .RD_VALID
);

// >>> tb/alc_trap_model.sv
// Purpose: trap logic model, records verdicts and read data
// Assumes: one verdict per response pulse
// Notes: counters let the bench wait without races
module alc_trap_model (
  input wire logic clk,
  input wire logic rsp_valid,
  input wire alc_pkg::alc_cause_t rsp_cause,
  input wire logic rsp_little,
  input wire logic rd_valid,
  input wire logic [63:0] rd_data
);
  timeunit 1ns;
  timeprecision 100ps;
  int count = 0;
  int rdn = 0;
  alc_pkg::alc_cause_t cause;
  logic little;
  logic [63:0] rdata;
  always @(posedge clk) begin
    if (rsp_valid) begin
      count <= count + 1;
      cause <= rsp_cause;
      little <= rsp_little;
    end
    if (rd_valid) begin
      rdn <= rdn + 1;
      rdata <= rd_data;
    end
  end
endmodule : alc_trap_model

// >>> tb/tb_asi_access_legality_checker.sv
// Purpose: directed tests of the space-id legality checker
// Assumes: default modes, reg4 denied, reg6 slow
// Notes: v nibbles are op, space, addr, {ie,s16,imm}, cause
module tb_asi_access_legality_checker;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic vld = 1'b0;
  logic imm = 1'b0;
  logic s16 = 1'b0;
  logic ie = 1'b0;
  alc_pkg::alc_op_t op = alc_pkg::OP_OTHER_ALT;
  logic [7:0] asi = 8'h00;
  logic [63:0] addr = 64'h0;
  logic [63:0] wd = 64'h0;
  logic rv, rl, dv, busy;
  alc_pkg::alc_cause_t rc;
  logic [63:0] rdd;
  int mismatches = 0;
  int checked = 0;
  // clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  alc_checker dut (
    .CORE_CLK(clk), .RSTN(rst_n), .REQ_VALID(vld), .REQ_OP(op), .REQ_ASI(asi), .REQ_ADDR(addr),
    .REQ_IMM(imm), .REQ_SHORT16(s16), .INVERT_ENDIAN_BIT(ie), .REQ_WDATA(wd), .RSP_VALID(rv),
    .RSP_CAUSE(rc), .RSP_PROCEED(), .RSP_REAL_ADDR(), .RSP_CTX(), .RSP_LITTLE(rl), .RSP_ATOMIC128(),
    .RSP_BLOCK(), .RSP_PARTIAL(), .RSP_SHORT(), .RSP_DEFER_TO_LOAD(), .RD_VALID(dv), .RD_DATA(rdd), .BUSY(busy)
  );
  alc_trap_model m (
    .clk(clk), .rsp_valid(rv), .rsp_cause(rc), .rsp_little(rl), .rd_valid(dv), .rd_data(rdd)
  );
  task automatic ck(input logic ok);
    checked++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t response differs", $time);
    end
  endtask : ck
  // one request, held one edge, then verdict compared
  task automatic req(input logic [27:0] v, input logic [63:0] d = 64'h0);
    int n;
    n = m.count;
    @(posedge clk);
    vld <= 1'b1;
    op <= alc_pkg::alc_op_t'(v[26:24]);
    asi <= v[23:16];
    addr <= {56'h0, v[15:8]};
    {ie, s16, imm} <= v[6:4];
    wd <= d;
    @(posedge clk);
    vld <= 1'b0;
    repeat (4) begin
      #1;
      if (m.count == n) @(posedge clk);
    end
    ck(m.count == n + 1 && m.cause === alc_pkg::alc_cause_t'(v[2:0]));
  endtask : req
  // scratch read; slow one also gets a request while busy
  task automatic rd(input int i, input logic [63:0] e);
    int n;
    int c;
    n = m.rdn;
    req({4'h3, 8'h20, 2'h0, i[2:0], 11'h0});
    c = m.count;
    if (i == 6) begin
      ck(busy === 1'b1);
      @(posedge clk);
      vld <= 1'b1;
      @(posedge clk);
      vld <= 1'b0;
    end
    repeat (12) if (m.rdn == n) @(posedge clk);
    #1;
    ck(m.count == c && m.rdn == n + 1 && m.rdata === e);
  endtask : rd
  // two fast scratch reads taken on adjacent edges, each word returned
  task automatic rd2(input logic [63:0] e0, input logic [63:0] e1);
    int n;
    n = m.rdn;
    @(posedge clk);
    vld <= 1'b1;
    op <= alc_pkg::OP_X_LOAD;
    asi <= alc_pkg::SP_SCRATCH;
    addr <= 64'h0;
    @(posedge clk);
    addr <= 64'h8;
    @(posedge clk);
    vld <= 1'b0;
    @(posedge clk);
    #1;
    ck(m.rdn == n + 1 && m.rdata === e0);
    @(posedge clk);
    #1;
    ck(m.rdn == n + 2 && m.rdata === e1);
  endtask : rd2
  task automatic finish_test;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  // watchdog
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    finish_test();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    req(28'h0261000);
    req(28'h0260802);
    req(28'h0E32040);
    ck(m.little === 1'b1);
    req(28'h02E0000);
    ck(m.little === 1'b1);
    req(28'h3E20101);
    req(28'h52E0001);
    req(28'h1F04000);
    req(28'h2F82002);
    req(28'h4160101);
    req(28'h6E00001);
    req(28'h1E01000);
    req(28'h2C00800);
    req(28'h2CD0402);
    req(28'h2C50313);
    req(28'h3C80311);
    req(28'h1D20122);
    req(28'h2D30220);
    req(28'h1DB0000);
    req(28'h3D00101);
    req(28'h1200801);
    req(28'h3202001);
    rd(0, 64'h0);
    for (int i = 0; i < 8; i++) begin
      if (i != 4) req({4'h4, 8'h20, 2'h0, i[2:0], 11'h0}, {32'h5A5A_0F0F, i});
    end
    for (int i = 0; i < 8; i++) begin
      if (i != 4) rd(i, {32'h5A5A_0F0F, i});
    end
    rd2({32'h5A5A_0F0F, 32'h0}, {32'h5A5A_0F0F, 32'h1});
    finish_test();
  end
endmodule : tb_asi_access_legality_checker
